// >>> hw/mats_params.svh
// register map, field positions, reset values and timing for the trigger scheduler
`ifndef MATS_PARAMS_SVH
`define MATS_PARAMS_SVH

`define MATS_ADDR_W        12
`define MATS_IDX_PWR       8'h0C
`define MATS_IDX_CTRL1     8'h90
`define MATS_IDX_CTRL2     8'h91
`define MATS_IDX_CFG       8'h92
`define MATS_IDX_STAT      8'h93
`define MATS_ADDR_PWR      12'h030
`define MATS_ADDR_CTRL1    12'h240
`define MATS_ADDR_CTRL2    12'h244
`define MATS_ADDR_CFG      12'h248
`define MATS_ADDR_STAT     12'h24C

`define MATS_PWR_EN_BIT    7
`define MATS_C1_EN_BIT     15
`define MATS_C1_MODE_BIT   14
`define MATS_C1_POLL_BIT   13
`define MATS_C1_SEL_MSB    7
`define MATS_C2_GATE_MSB   13
`define MATS_C2_GATE_LSB   12
`define MATS_C2_RATE_MSB   10
`define MATS_C2_RATE_LSB   8
`define MATS_CFG_POL_BIT   0
`define MATS_ST_FLAG_BIT   0
`define MATS_ST_BUSY_BIT   1

`define MATS_SEL_RST       8'h00
`define MATS_GATE_RST      2'h0
`define MATS_RATE_RST      3'h0
`define MATS_POL_RST       1'b1
`define MATS_CLK_HZ        100000000
`define MATS_RATE_BASE_HZ  1
`define MATS_RESP_OKAY     2'h0
`define MATS_RESP_SLVERR   2'h2

`endif

// >>> hw/mats_pkg.sv
// types shared by the trigger scheduler files
package mats_pkg;
  typedef enum logic [2:0]
  {
    MATS_S_IDLE  = 3'b001,
    MATS_S_ISSUE = 3'b010,
    MATS_S_WAIT  = 3'b100
  } mats_state_t;

  typedef enum logic [1:0]
  {
    MATS_GATE_IGNORE  = 2'h0,
    MATS_GATE_INHIBIT = 2'h1,
    MATS_GATE_RSVD    = 2'h2,
    MATS_GATE_TRIGGER = 2'h3
  } mats_gate_t;

  typedef logic [2:0] mats_rate_t;
endpackage : mats_pkg

// >>> hw/mats_rate_timer.sv
// periodic start tick for continuous scheduling
`timescale 1ns/100ps
`include "mats_params.svh"
module mats_rate_timer
#(
  parameter int CLK_HZ = `MATS_CLK_HZ
)
(
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             run,
  input  wire mats_pkg::mats_rate_t repeat_rate_sel,
  // tick out
  output logic                  tick
);
  import mats_pkg::*;

  localparam int BASE_HZ = `MATS_RATE_BASE_HZ;

  logic [31:0] cnt_reg;
  logic        tick_reg;
  logic [3:0]  hz_shift;
  logic [31:0] period_m1;

  // code 0 is the base rate, code n above it is base times 2^(n+1)
  assign hz_shift  = (repeat_rate_sel == 3'h0) ? 4'h0 : ({1'b0, repeat_rate_sel} + 4'h1);
  assign period_m1 = 32'(CLK_HZ / (BASE_HZ << hz_shift)) - 32'h1;
  assign tick      = tick_reg;

  // a new rate takes effect at the next reload, not mid-interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg == 32'h0)
    begin
      cnt_reg  <= period_m1;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_reg - 32'h1;
      tick_reg <= 1'b0;
    end
  end

  a_tick_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    run && cnt_reg == 32'h0 |=> tick_reg && cnt_reg == $past(period_m1))
    else $error("rate timer reload wrong");
endmodule : mats_rate_timer

// >>> hw/mats_top.sv
// trigger scheduler for the housekeeping converter, with its register slave
// Operation
// - eight inputs, each selectable; a trigger converts every selected input once.
// - select bits 7:0 of control one: four pins, usb, line, battery, temperature.
// - all select bits are zero after reset.
// - control one bit 14 picks polling (0) or continuous (1); resets 0.
// - writing 1 to bit 13 starts a polled set; clears itself when done.
// - after a polled set the converter stays idle until a new trigger.
// - continuous sets repeat at rate field 10:8, 1Hz up to 256Hz.
// - gate field 13:12: 00 ignore, 01 inhibit while asserted, 10 reserved.
// - gate field 11 makes the pin the only trigger source.
// - in pin mode each active edge that finds the scheduler enabled and idle starts one set; polarity picks edge.
// - enable bit lives at power bit 7 and control one bit 15, shared.
// - a result-ready flag rises whenever new conversion data is available.
`timescale 1ns/100ps
`include "mats_params.svh"
module mats_top
#(
  parameter int CLK_HZ = `MATS_CLK_HZ
)
(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address and data
  input  wire logic [`MATS_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // axi4-lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [`MATS_ADDR_W-1:0] araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // gate pin, asynchronous
  input  wire logic                    gate_pin,
  // converter handshake
  output logic                         conv_req,
  output logic [2:0]                   conv_chan,
  input  wire logic                    conv_done,
  // status
  output logic                         result_ready_flag,
  output logic                         set_busy
);
  import mats_pkg::*;

  // bus state
  logic                    awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]              bresp_reg, rresp_reg;
  logic [31:0]             rdata_reg;
  logic                    aw_hold_reg, w_hold_reg;
  logic [`MATS_ADDR_W-1:0] waddr_reg;
  logic [31:0]             wdata_reg;
  logic [3:0]              wstrb_reg;
  // control state
  logic                    en_reg, sched_mode_sel_reg, poll_reg, pol_reg, flag_reg;
  logic [7:0]              incl_reg, pend_reg;
  mats_gate_t              gate_mode_reg;
  mats_rate_t              rate_reg;
  mats_state_t             state_reg, state_next;
  logic                    conv_req_reg;
  logic                    busy_reg;
  logic [2:0]              conv_chan_reg;
  logic                    gate_meta_reg, gate_sync_reg, gate_prev_reg;

  assign awready           = awready_reg;
  assign wready            = wready_reg;
  assign bvalid            = bvalid_reg;
  assign bresp             = bresp_reg;
  assign arready           = arready_reg;
  assign rvalid            = rvalid_reg;
  assign rresp             = rresp_reg;
  assign rdata             = rdata_reg;
  assign conv_req          = conv_req_reg;
  assign conv_chan         = conv_chan_reg;
  assign result_ready_flag = flag_reg;
  assign set_busy          = busy_reg;

  // write channel: address and data taken in either order, executed together
  logic aw_hs, w_hs, wr_exec, aw_hold_next, w_hold_next, ar_hs, rvalid_next;
  assign aw_hs        = awvalid && awready_reg;
  assign w_hs         = wvalid && wready_reg;
  assign wr_exec      = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign aw_hold_next = (aw_hold_reg || aw_hs) && !wr_exec;
  assign w_hold_next  = (w_hold_reg || w_hs) && !wr_exec;
  assign ar_hs        = arvalid && arready_reg;
  assign rvalid_next  = ar_hs || (rvalid_reg && !rready);

  // write decode
  logic wr_pwr, wr_c1, wr_c2, wr_cfg, wr_hit, lo_en, hi_en;
  assign wr_pwr = wr_exec && (waddr_reg == `MATS_ADDR_PWR);
  assign wr_c1  = wr_exec && (waddr_reg == `MATS_ADDR_CTRL1);
  assign wr_c2  = wr_exec && (waddr_reg == `MATS_ADDR_CTRL2);
  assign wr_cfg = wr_exec && (waddr_reg == `MATS_ADDR_CFG);
  assign wr_hit = wr_pwr || wr_c1 || wr_c2 || wr_cfg || (waddr_reg == `MATS_ADDR_STAT);
  assign lo_en  = wstrb_reg[0];
  assign hi_en  = wstrb_reg[1];

  // read decode
  logic rd_pwr, rd_c1, rd_c2, rd_cfg, rd_st, rd_hit, rd_clear;
  logic [15:0] rd_word;
  assign rd_pwr   = (araddr == `MATS_ADDR_PWR);
  assign rd_c1    = (araddr == `MATS_ADDR_CTRL1);
  assign rd_c2    = (araddr == `MATS_ADDR_CTRL2);
  assign rd_cfg   = (araddr == `MATS_ADDR_CFG);
  assign rd_st    = (araddr == `MATS_ADDR_STAT);
  assign rd_hit   = rd_pwr || rd_c1 || rd_c2 || rd_cfg || rd_st;
  assign rd_clear = ar_hs && rd_st;
  assign rd_word  = rd_pwr ? {8'h00, en_reg, 7'h00} :
                    rd_c1  ? {en_reg, sched_mode_sel_reg, poll_reg, 5'h00, incl_reg} :
                    rd_c2  ? {2'h0, gate_mode_reg, 1'b0, rate_reg, 8'h00} :
                    rd_cfg ? {15'h0000, pol_reg} :
                    rd_st  ? {14'h0000, set_busy, flag_reg} : 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MATS_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `MATS_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      waddr_reg   <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awready_reg <= !aw_hold_next;
      wready_reg  <= !w_hold_next;
      arready_reg <= !rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (aw_hs)
        waddr_reg <= awaddr;
      if (w_hs)
      begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_exec)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `MATS_RESP_OKAY : `MATS_RESP_SLVERR;
      end
      else if (bready)
        bvalid_reg <= 1'b0;
      if (ar_hs)
      begin
        rdata_reg <= {16'h0000, rd_word};
        rresp_reg <= rd_hit ? `MATS_RESP_OKAY : `MATS_RESP_SLVERR;
      end
    end
  end

  // gate pin synchroniser; level taken from the second stage, edges from the second and third
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
    end
    else
    begin
      gate_meta_reg <= gate_pin;
      gate_sync_reg <= gate_meta_reg;
      gate_prev_reg <= gate_sync_reg;
    end
  end

  // trigger sources
  logic gate_trig_mode, gate_asserted, inhibit, active_edge, tick;
  logic poll_trig, cont_trig, pin_trig, start_pulse, set_done, timer_run;
  assign gate_trig_mode = (gate_mode_reg == MATS_GATE_TRIGGER);
  assign gate_asserted  = (gate_sync_reg == pol_reg);
  assign inhibit        = (gate_mode_reg == MATS_GATE_INHIBIT) && gate_asserted;
  assign active_edge    = pol_reg ? (gate_sync_reg && !gate_prev_reg)
                                  : (!gate_sync_reg && gate_prev_reg);
  assign poll_trig      = wr_c1 && hi_en && wdata_reg[`MATS_C1_POLL_BIT]
                          && !sched_mode_sel_reg && !gate_trig_mode;
  assign cont_trig      = tick && sched_mode_sel_reg && !gate_trig_mode;
  assign pin_trig       = gate_trig_mode && active_edge;
  // busy or disabled: the trigger is dropped, nothing is remembered
  assign start_pulse    = en_reg && (state_reg == MATS_S_IDLE) && !inhibit
                          && (poll_trig || cont_trig || pin_trig);
  assign timer_run      = en_reg && sched_mode_sel_reg && !gate_trig_mode;

  mats_rate_timer #(
    .CLK_HZ          (CLK_HZ)
  ) u_rate_timer (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .run             (timer_run),
    .repeat_rate_sel (rate_reg),
    .tick            (tick)
  );

  // register file
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_reg             <= 1'b0;
      sched_mode_sel_reg <= 1'b0;
      incl_reg           <= `MATS_SEL_RST;
      gate_mode_reg      <= mats_gate_t'(`MATS_GATE_RST);
      rate_reg           <= `MATS_RATE_RST;
      pol_reg            <= `MATS_POL_RST;
    end
    else
    begin
      if (wr_pwr && lo_en)
        en_reg <= wdata_reg[`MATS_PWR_EN_BIT];
      else if (wr_c1 && hi_en)
        en_reg <= wdata_reg[`MATS_C1_EN_BIT];
      if (wr_c1 && hi_en)
        sched_mode_sel_reg <= wdata_reg[`MATS_C1_MODE_BIT];
      if (wr_c1 && lo_en)
        incl_reg <= wdata_reg[`MATS_C1_SEL_MSB:0];
      if (wr_c2 && hi_en)
      begin
        gate_mode_reg <= mats_gate_t'(wdata_reg[`MATS_C2_GATE_MSB:`MATS_C2_GATE_LSB]);
        rate_reg      <= wdata_reg[`MATS_C2_RATE_MSB:`MATS_C2_RATE_LSB];
      end
      if (wr_cfg && lo_en)
        pol_reg <= wdata_reg[`MATS_CFG_POL_BIT];
    end
  end

  // conversion sequencer, lowest selected input first
  logic [7:0] low_bit, chan_onehot;
  logic [2:0] low_idx;
  logic       last_conv;
  assign low_bit     = pend_reg & (~pend_reg + 8'h01);
  assign low_idx     = {|low_bit[7:4], |(low_bit & 8'hCC), |(low_bit & 8'hAA)};
  assign chan_onehot = 8'h01 << conv_chan_reg;
  assign last_conv   = (pend_reg & ~chan_onehot) == 8'h00;
  assign set_done    = ((state_reg == MATS_S_ISSUE) && pend_reg == 8'h00)
                       || ((state_reg == MATS_S_WAIT) && conv_done && last_conv);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MATS_S_IDLE:  if (start_pulse) state_next = MATS_S_ISSUE;
      MATS_S_ISSUE: state_next = (pend_reg == 8'h00) ? MATS_S_IDLE : MATS_S_WAIT;
      MATS_S_WAIT:  if (conv_done) state_next = last_conv ? MATS_S_IDLE : MATS_S_ISSUE;
      default:      state_next = MATS_S_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= MATS_S_IDLE;
      pend_reg      <= 8'h00;
      conv_req_reg  <= 1'b0;
      conv_chan_reg <= 3'h0;
      poll_reg      <= 1'b0;
      flag_reg      <= 1'b0;
      busy_reg      <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      // busy pin from its own flop, same timing as the state
      busy_reg  <= (state_next != MATS_S_IDLE);
      if (start_pulse)
        pend_reg <= incl_reg;
      else if ((state_reg == MATS_S_WAIT) && conv_done)
        pend_reg <= pend_reg & ~chan_onehot;
      if ((state_reg == MATS_S_ISSUE) && pend_reg != 8'h00)
      begin
        conv_req_reg  <= 1'b1;
        conv_chan_reg <= low_idx;
      end
      else if (conv_done)
        conv_req_reg <= 1'b0;
      if (start_pulse && poll_trig)
        poll_reg <= 1'b1;
      else if (set_done)
        poll_reg <= 1'b0;
      // new data beats a status read in the same cycle
      if ((state_reg == MATS_S_WAIT) && conv_done)
        flag_reg <= 1'b1;
      else if (rd_clear)
        flag_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_select_reset_zero: assert property ($rose(aresetn) |-> incl_reg == 8'h00)
    else $error("select bits not zero after reset");
  a_start_needs_en: assert property ((state_reg == MATS_S_IDLE) && !en_reg |=> state_reg == MATS_S_IDLE)
    else $error("set started while disabled");
  a_busy_drop: assert property ((state_reg != MATS_S_IDLE) && !((state_reg == MATS_S_WAIT) && conv_done)
    |=> pend_reg == $past(pend_reg))
    else $error("trigger accepted while busy");
  a_poll_self_clear: assert property (poll_reg && set_done |=> !poll_reg)
    else $error("poll bit not cleared at set end");
  a_idle_holds: assert property ((state_reg == MATS_S_IDLE) && !start_pulse |=> state_reg == MATS_S_IDLE)
    else $error("left idle without trigger");
  a_gate_inhibit: assert property ((gate_mode_reg == MATS_GATE_INHIBIT) && gate_asserted
    && (state_reg == MATS_S_IDLE) |=> state_reg == MATS_S_IDLE)
    else $error("start while gate inhibits");
  a_pin_only_src: assert property (gate_trig_mode && start_pulse |-> pin_trig && !poll_trig)
    else $error("non-pin start in pin mode");
  a_edge_one_set: assert property (pin_trig && en_reg && (state_reg == MATS_S_IDLE)
    |=> state_reg == MATS_S_ISSUE ##1 state_reg != MATS_S_IDLE || pend_reg == 8'h00)
    else $error("pin edge did not start a set");
  a_chan_cleared: assert property ((state_reg == MATS_S_WAIT) && conv_done
    |=> pend_reg == ($past(pend_reg) & ~$past(chan_onehot)))
    else $error("converted input not retired");
  a_flag_on_data: assert property ((state_reg == MATS_S_WAIT) && conv_done |=> flag_reg)
    else $error("result flag not raised");
  a_en_alias: assert property (wr_pwr && lo_en |=> en_reg == $past(wdata_reg[`MATS_PWR_EN_BIT]))
    else $error("enable alias write lost");
  a_mode_write: assert property (wr_c1 && hi_en |=> sched_mode_sel_reg == $past(wdata_reg[`MATS_C1_MODE_BIT]))
    else $error("mode bit write lost");
  a_sel_readback: assert property (ar_hs && rd_c1 && !(wr_c1 && lo_en) |=> rdata_reg[7:0] == $past(incl_reg))
    else $error("select readback wrong");

  c_poll_set: cover property (start_pulse && poll_trig);
  c_cont_set: cover property (start_pulse && cont_trig);
  c_pin_set: cover property (start_pulse && pin_trig);
  c_inhibited: cover property (inhibit && (poll_trig || cont_trig));
endmodule : mats_top

// >>> tb/mats_conv_model.sv
// converter model for the trigger scheduler bench: answers requests and logs them
`timescale 1ns/100ps
module mats_conv_model
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // converter handshake
  input  wire logic       conv_req,
  input  wire logic [2:0] conv_chan,
  output logic            conv_done = 1'b0,
  // bench control and log
  input  wire logic       set_busy,
  input  wire logic [7:0] dly,
  input  wire logic       clr,
  output logic [7:0]      cnt = 8'h00,
  output logic [7:0]      seen = 8'h00,
  output logic            order_bad = 1'b0
);
  logic [7:0] wait_reg = 8'h00;
  // last channel plus one, zero between sets
  logic [3:0] prev_reg = 4'h0;

  always @(posedge aclk)
  begin
    if (!set_busy)
      prev_reg <= 4'h0;
    if (!aresetn || clr)
    begin
      conv_done <= 1'b0;
      wait_reg  <= 8'h00;
      cnt       <= 8'h00;
      seen      <= 8'h00;
    end
    else if (conv_done)
      conv_done <= 1'b0;
    else if (conv_req)
    begin
      // slow answers come from dly, so a set can be made to last
      if (wait_reg >= dly)
      begin
        conv_done       <= 1'b1;
        wait_reg        <= 8'h00;
        cnt             <= cnt + 8'h01;
        seen[conv_chan] <= 1'b1;
        prev_reg        <= {1'b0, conv_chan} + 4'h1;
        if ({1'b0, conv_chan} < prev_reg)
          order_bad <= 1'b1;
      end
      else
        wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule : mats_conv_model

// >>> tb/monitor_adc_trigger_scheduler_test.sv
// register-level bench for the trigger scheduler
`timescale 1ns/100ps
`include "mats_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module monitor_adc_trigger_scheduler_test;
  import mats_pkg::*;
  localparam int HZ = 2560;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  wstrb = 0;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, conv_req, conv_done, flag, set_busy;
  logic        gate_pin = 0, clr = 0, order_bad;
  logic [2:0]  conv_chan;
  logic [7:0]  dly = 8'h14, cnt, seen;
  logic [31:0] d;
  int          num_errors = 0, num_checks = 0;

  always #5 aclk = ~aclk;

  mats_top #(.CLK_HZ(HZ)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .gate_pin(gate_pin),
    .conv_req(conv_req), .conv_chan(conv_chan), .conv_done(conv_done), .result_ready_flag(flag),
    .set_busy(set_busy));

  mats_conv_model conv (.aclk(aclk), .aresetn(aresetn), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_done(conv_done), .set_busy(set_busy), .dly(dly), .clr(clr), .cnt(cnt), .seen(seen),
    .order_bad(order_bad));

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er = `MATS_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, v};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    `CHK("bvalid", 1'b1, bvalid)
    bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = `MATS_RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    `CHK("rvalid", 1'b1, rvalid)
    rready <= 1'b0;
    `CHK("rresp", er, r)
    `CHK("rdata", e, d)
  endtask : rd

  task automatic clear_log;
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask : clear_log

  // bounded wait for the set in progress to end
  task automatic wait_idle;
    int n;
    n = 0;
    cyc(3);
    while (set_busy !== 1'b0 && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK("idle", 1'b0, set_busy)
    cyc(2);
  endtask : wait_idle

  initial
  begin
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    rd(`MATS_ADDR_CTRL1, 32'h0);
    rd(`MATS_ADDR_CTRL2, 32'h0);
    rd(`MATS_ADDR_PWR, 32'h0);
    rd(`MATS_ADDR_CFG, 32'h1);
    rd(`MATS_ADDR_STAT, 32'h0);
    rd(12'h100, 32'h0, `MATS_RESP_SLVERR);
    wr(12'h100, 16'hFFFF, `MATS_RESP_SLVERR);
    // poll with converter off must do nothing
    wr(`MATS_ADDR_CTRL1, 16'h2081);
    cyc(30);
    `CHK("count", 8'h00, cnt)
    wr(`MATS_ADDR_PWR, 16'h0080);
    rd(`MATS_ADDR_CTRL1, 32'h8081);
    wr(`MATS_ADDR_CTRL1, 16'h0081);
    rd(`MATS_ADDR_PWR, 32'h0);
    wr(`MATS_ADDR_PWR, 16'h0080);
    // slow polled set, second poll lands while busy
    clear_log;
    // selection lands before the poll write; the start snapshots the old value
    wr(`MATS_ADDR_CTRL1, 16'h80A5);
    wr(`MATS_ADDR_CTRL1, 16'hA0A5);
    rd(`MATS_ADDR_CTRL1, 32'hA0A5);
    wr(`MATS_ADDR_CTRL1, 16'hA0A5);
    wait_idle;
    `CHK("count", 8'h04, cnt)
    `CHK("channels", 8'hA5, seen)
    rd(`MATS_ADDR_CTRL1, 32'h80A5);
    cyc(50);
    `CHK("count", 8'h04, cnt)
    `CHK("flag", 1'b1, flag)
    rd(`MATS_ADDR_STAT, 32'h1);
    rd(`MATS_ADDR_STAT, 32'h0);
    `CHK("flag", 1'b0, flag)
    dly <= 8'h01;
    wr(`MATS_ADDR_CTRL1, 16'h8001);
    // inhibit while gate asserted, reserved code ignores gate
    wr(`MATS_ADDR_CTRL2, {2'b00, MATS_GATE_INHIBIT, 12'h000});
    gate_pin <= 1'b1;
    clear_log;
    wr(`MATS_ADDR_CTRL1, 16'hA001);
    cyc(30);
    `CHK("count", 8'h00, cnt)
    gate_pin <= 1'b0;
    cyc(4);
    wr(`MATS_ADDR_CTRL1, 16'hA001);
    wait_idle;
    `CHK("count", 8'h01, cnt)
    wr(`MATS_ADDR_CTRL2, {2'b00, MATS_GATE_RSVD, 12'h000});
    gate_pin <= 1'b1;
    clear_log;
    wr(`MATS_ADDR_CTRL1, 16'hA001);
    wait_idle;
    `CHK("count", 8'h01, cnt)
    gate_pin <= 1'b0;
    // every rate code: one set at once, then one per period
    for (int c = 0; c < 8; c++)
    begin
      wr(`MATS_ADDR_CTRL1, 16'h8001);
      wr(`MATS_ADDR_CTRL2, {5'h00, c[2:0], 8'h00});
      wr(`MATS_ADDR_CTRL1, 16'hC001);
      clear_log;
      cyc(2 * (HZ >> ((c == 0) ? 0 : c + 1)) + 5);
      `CHK("rate sets", 8'h03, cnt)
    end
    // pin mode: only active edges start sets
    wr(`MATS_ADDR_CTRL2, {2'b00, MATS_GATE_TRIGGER, 12'h700});
    clear_log;
    wr(`MATS_ADDR_CTRL1, 16'hE001);
    cyc(40);
    `CHK("count", 8'h00, cnt)
    gate_pin <= 1'b1;
    cyc(40);
    `CHK("count", 8'h01, cnt)
    gate_pin <= 1'b0;
    cyc(40);
    `CHK("count", 8'h01, cnt)
    gate_pin <= 1'b1;
    cyc(40);
    wr(`MATS_ADDR_CFG, 16'h0000);
    gate_pin <= 1'b0;
    cyc(40);
    `CHK("count", 8'h03, cnt)
    gate_pin <= 1'b1;
    cyc(40);
    `CHK("count", 8'h03, cnt)
    `CHK("ascending", 1'b0, order_bad)
    test_done;
  end

  initial
  begin
    cyc(60000);
    num_errors++;
    $display("[ERR] watchdog expected end seen hang");
    test_done;
  end
endmodule : monitor_adc_trigger_scheduler_test
